// File: hw/srs_top.sv
// startup reset sequencer: reset merge, power-on reset, clock request, sleep timing
//
// Operation
// - chip reset held while pin or POR asserted
// - POR about 3 ms, never under 1.5 ms
// - startup from reset pin or power-up alone
// - clock request about 120 us after release
// - sleep at least 4.2 ms after release
// - no low-power clock activity selects internal oscillator
// - no oscillator module means crystal reference
`timescale 1ns/1ps
`default_nettype none
module srs_top
  import srs_pkg::*;
#(
  parameter logic [CNT_W-1:0] POR_CNT = POR_CYCLES,
  parameter logic [CNT_W-1:0] CLKREQ_CNT = CLKREQ_CYCLES,
  parameter logic [CNT_W-1:0] SLEEP_CNT = SLEEP_CYCLES,
  parameter logic [LPO_CNT_W-1:0] LPO_WINDOW = LPO_WINDOW_CYCLES,
  parameter logic HAS_CLK_REQ = 1'b1
)
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // external pins
  input wire logic EXT_RESET_N_IN,
  input wire logic CORE_SUPPLY_OK_IN,
  input wire logic LOW_POWER_OSC_CLOCK_IN,
  input wire logic TCXO_PRESENT_IN,
  // sequencing outputs
  output logic CHIP_RESET_N_OUT,
  output logic POR_ACTIVE_OUT,
  output logic CLK_REQ_OUT,
  output logic SLEEP_OUT,
  output logic STARTUP_DONE_OUT,
  // clock source selection
  output logic LPO_INTERNAL_SEL_OUT,
  output logic REF_CRYSTAL_SEL_OUT
);
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  logic [CNT_W-1:0] por_cnt_ff;
  logic por_active_ff;
  logic chip_reset_n_ff;
  logic [CNT_W-1:0] rel_cnt_ff;
  logic clk_req_ff;
  logic sleep_ff;
  logic done_ff;
  logic lpo_internal_ff;
  logic ref_crystal_ff;
  srs_state_type state_ff;
  srs_state_type nxt_state;
  logic ext_asserted;
  logic sleep_over;
  // floor keeps its ratio to the configured count, so shortened counts stay checkable
  localparam logic [CNT_W-1:0] POR_FLOOR = CNT_W'(longint'(POR_CNT) * POR_MIN_NS / POR_TYP_NS);

  srs_lpo_if lpo_bus ();

  srs_lpo_detect #(
    .WINDOW_CYCLES(LPO_WINDOW)
  ) u_lpo_detect (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .lpo_pin_in(LOW_POWER_OSC_CLOCK_IN),
    .lpo(lpo_bus.det)
  );

  assign ext_asserted = !pin_sync_ff[PIN_EXT_RST_N];
  assign sleep_over = (rel_cnt_ff >= SLEEP_CNT);

  // ==========================================================
  // two-stage synchronisers for the static pins
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pin_meta_ff <= PIN_RESET_VAL;
      pin_sync_ff <= PIN_RESET_VAL;
    end
    else
    begin
      pin_meta_ff <= {TCXO_PRESENT_IN, CORE_SUPPLY_OK_IN, EXT_RESET_N_IN};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ==========================================================
  // power-on reset: restarts whenever the supply drops out
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      por_cnt_ff <= CNT_ZERO;
      por_active_ff <= 1'b1;
    end
    else
    begin
      if (!pin_sync_ff[PIN_SUPPLY_OK])
        por_cnt_ff <= CNT_ZERO;
      else if (por_cnt_ff != POR_CNT)
        por_cnt_ff <= por_cnt_ff + 20'h00001;
      por_active_ff <= !pin_sync_ff[PIN_SUPPLY_OK] || (por_cnt_ff != POR_CNT);
    end
  end

  // ==========================================================
  // global reset: last of pin and POR to release wins
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      chip_reset_n_ff <= 1'b0;
    else
      chip_reset_n_ff <= !(ext_asserted || por_active_ff);
  end

  // ==========================================================
  // time since release, saturating once sleep is over
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      rel_cnt_ff <= CNT_ZERO;
    else if (!chip_reset_n_ff)
      rel_cnt_ff <= CNT_ZERO;
    else if (!sleep_over)
      rel_cnt_ff <= rel_cnt_ff + 20'h00001;
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HELD:
        if (chip_reset_n_ff)
          nxt_state = ST_SLEEP;
      ST_SLEEP:
        if (!chip_reset_n_ff)
          nxt_state = ST_HELD;
        else if (sleep_over)
          nxt_state = ST_RUN;
      ST_RUN:
        if (!chip_reset_n_ff)
          nxt_state = ST_HELD;
      default:
        nxt_state = ST_HELD;
    endcase
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      state_ff <= ST_HELD;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // sequencing outputs; clock request stays up until reset returns
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      clk_req_ff <= 1'b0;
      sleep_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else
    begin
      clk_req_ff <= HAS_CLK_REQ && chip_reset_n_ff && (rel_cnt_ff >= CLKREQ_CNT);
      sleep_ff <= (nxt_state != ST_RUN);
      done_ff <= (nxt_state == ST_RUN);
    end
  end

  // ==========================================================
  // clock sources judged as sleep ends, when they must be stable
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      lpo_internal_ff <= 1'b1;
      ref_crystal_ff <= 1'b1;
    end
    else if (state_ff == ST_SLEEP && nxt_state == ST_RUN)
    begin
      // a missing verdict (valid low, no window finished yet) counts as no external clock
      lpo_internal_ff <= !(lpo_bus.present && lpo_bus.valid);
      ref_crystal_ff <= !pin_sync_ff[PIN_TCXO];
    end
  end

  assign CHIP_RESET_N_OUT = chip_reset_n_ff;
  assign POR_ACTIVE_OUT = por_active_ff;
  assign CLK_REQ_OUT = clk_req_ff;
  assign SLEEP_OUT = sleep_ff;
  assign STARTUP_DONE_OUT = done_ff;
  assign LPO_INTERNAL_SEL_OUT = lpo_internal_ff;
  assign REF_CRYSTAL_SEL_OUT = ref_crystal_ff;

  // ==========================================================
  // checks
  sequence s_por_done_pin_free;
    !por_active_ff && !ext_asserted && !chip_reset_n_ff;
  endsequence

  sequence s_release_seen;
    $rose(chip_reset_n_ff);
  endsequence

  a_reset_merge_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (ext_asserted || por_active_ff) |=> !chip_reset_n_ff)
    else $error("chip left reset while a reset source was active");

  a_por_min_len: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $fell(por_active_ff) |-> ($past(por_cnt_ff) >= POR_FLOOR && $past(por_cnt_ff) == POR_CNT))
    else $error("power-on reset released too early");

  a_por_only_boot: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_por_done_pin_free |=> chip_reset_n_ff ##1 (state_ff == ST_SLEEP))
    else $error("startup did not follow reset release");

  a_clkreq_delay: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $rose(clk_req_ff) |-> ($past(rel_cnt_ff) == CLKREQ_CNT && chip_reset_n_ff == $past(chip_reset_n_ff)))
    else $error("clock request rose at the wrong time");

  a_clkreq_drop: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !chip_reset_n_ff |=> !clk_req_ff)
    else $error("clock request held through reset");

  a_sleep_min_len: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $fell(sleep_ff) |-> ($past(rel_cnt_ff) >= SLEEP_CNT && done_ff))
    else $error("sleep ended before minimum interval");

  a_sleep_on_release: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_release_seen |-> sleep_ff [*2])
    else $error("sleep not held after release");

  a_lpo_select: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $rose(done_ff) |-> (lpo_internal_ff == !($past(lpo_bus.present) && $past(lpo_bus.valid))))
    else $error("low-power clock source chosen wrongly");

  a_ref_select: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    $rose(done_ff) |-> (ref_crystal_ff == !$past(pin_sync_ff[PIN_TCXO])))
    else $error("reference source chosen wrongly");
endmodule : srs_top
`default_nettype wire

// File: pkg/srs_pkg.sv
// constants shared by the startup reset sequencer
`default_nettype none
package srs_pkg;
  // ==========================================================
  // clock and counter geometry
  localparam int CLK_PERIOD_NS = 5;
  localparam int CNT_W = 20;
  localparam int LPO_CNT_W = 16;
  // ==========================================================
  // times in ns, as specified
  localparam int POR_TYP_NS = 3000000;
  localparam int POR_MIN_NS = 1500000;
  localparam int CLKREQ_DELAY_NS = 120000;
  localparam int SLEEP_MIN_NS = 4200000;
  // two periods of a 32.768 kHz clock, with margin
  localparam int LPO_WINDOW_NS = 100000;
  // ==========================================================
  // derived cycle counts (least times round up)
  localparam logic [CNT_W-1:0] POR_CYCLES = CNT_W'((POR_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] POR_MIN_CYCLES = CNT_W'((POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CLKREQ_CYCLES = CNT_W'((CLKREQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SLEEP_CYCLES = CNT_W'((SLEEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [LPO_CNT_W-1:0] LPO_WINDOW_CYCLES =
    LPO_CNT_W'((LPO_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================================
  // reset values and pin sync layout
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [LPO_CNT_W-1:0] LPO_CNT_ZERO = 16'h0000;
  localparam int PIN_W = 3;
  localparam int PIN_EXT_RST_N = 0;
  localparam int PIN_SUPPLY_OK = 1;
  localparam int PIN_TCXO = 2;
  localparam logic [PIN_W-1:0] PIN_RESET_VAL = 3'h1;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {ST_HELD, ST_SLEEP, ST_RUN} srs_state_type;
endpackage : srs_pkg
`default_nettype wire

// File: pkg/srs_lpo_if.sv
// low-power clock detection result passed to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface srs_lpo_if;
  logic present;
  logic valid;
  modport det (output present, output valid);
  modport seq (input present, input valid);
endinterface : srs_lpo_if
`default_nettype wire

// File: hw/srs_lpo_detect.sv
// activity detector for the external low-power clock pin
`timescale 1ns/1ps
`default_nettype none
module srs_lpo_detect
  import srs_pkg::*;
#(
  parameter logic [LPO_CNT_W-1:0] WINDOW_CYCLES = LPO_WINDOW_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lpo_pin_in,
  srs_lpo_if.det lpo
);
  logic sync0_ff;
  logic sync1_ff;
  logic prev_ff;
  logic seen_ff;
  logic present_ff;
  logic valid_ff;
  logic [LPO_CNT_W-1:0] win_cnt_ff;
  logic edge_seen;
  logic win_end;

  assign edge_seen = sync1_ff ^ prev_ff;
  assign win_end = (win_cnt_ff == WINDOW_CYCLES - 16'h0001);
  assign lpo.present = present_ff;
  assign lpo.valid = valid_ff;

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sync0_ff <= 1'b0;
      sync1_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      sync0_ff <= lpo_pin_in;
      sync1_ff <= sync0_ff;
      prev_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // window: absence of any edge for a whole window means no clock
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      win_cnt_ff <= LPO_CNT_ZERO;
      seen_ff <= 1'b0;
      present_ff <= 1'b0;
      valid_ff <= 1'b0;
    end
    else if (win_end)
    begin
      win_cnt_ff <= LPO_CNT_ZERO;
      seen_ff <= 1'b0;
      present_ff <= seen_ff | edge_seen;
      valid_ff <= 1'b1;
    end
    else
    begin
      win_cnt_ff <= win_cnt_ff + 16'h0001;
      seen_ff <= seen_ff | edge_seen;
    end
  end

  a_lpo_absent_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (win_end && !seen_ff && !edge_seen) |=> (!present_ff && valid_ff))
    else $error("idle low-power clock not reported absent");
endmodule : srs_lpo_detect
`default_nettype wire

// File: tb/srs_sys_model.sv
// system-side model: reset pin, supply monitor and board clocks
`timescale 1ns/1ps
`default_nettype none
module srs_sys_model
  import srs_pkg::*;
(
  // controls from the bench
  input wire logic hold_reset_in,
  input wire logic supply_on_in,
  input wire logic lpo_run_in,
  input wire logic tcxo_fit_in,
  // pins toward the device
  output logic ext_reset_n_out,
  output logic supply_ok_out,
  output var logic lpo_clk_out,
  output logic tcxo_present_out
);
  // ==========================================================
  // reset, supply and oscillator module presence
  assign ext_reset_n_out = !hold_reset_in;
  assign supply_ok_out = supply_on_in;
  assign tcxo_present_out = tcxo_fit_in;
  // ==========================================================
  // low-power clock, scaled down; stands low when absent
  initial lpo_clk_out = 1'b0;
  always #15 lpo_clk_out = lpo_run_in ? !lpo_clk_out : 1'b0;
endmodule : srs_sys_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the startup reset sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srs_pkg::*;
  // ==========================================================
  // signals
  localparam logic [CNT_W-1:0] T_POR = 20'h00028;
  localparam logic [CNT_W-1:0] T_REQ = 20'h00005;
  localparam logic [CNT_W-1:0] T_SLP = 20'h0003C;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold_rst = 1'b0;
  logic sup_on = 1'b0;
  logic lpo_run = 1'b0;
  logic tcxo_fit = 1'b0;
  logic ext_rst_n, sup_ok, lpo_clk, tcxo_pres;
  logic chip_rst_n, por_act, clk_req, sleep, done, lpo_int, xtal_sel;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 clk = !clk;
  srs_sys_model i_srs_sys_model (.hold_reset_in(hold_rst), .supply_on_in(sup_on), .lpo_run_in(lpo_run),
    .tcxo_fit_in(tcxo_fit), .ext_reset_n_out(ext_rst_n), .supply_ok_out(sup_ok), .lpo_clk_out(lpo_clk),
    .tcxo_present_out(tcxo_pres));
  // short counts keep the run brief: POR 40, clock request 5, sleep 60 cycles, not in the real ratios
  srs_top #(.POR_CNT(T_POR), .CLKREQ_CNT(T_REQ), .SLEEP_CNT(T_SLP), .LPO_WINDOW(16'h0010)) i_srs_top (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .EXT_RESET_N_IN(ext_rst_n), .CORE_SUPPLY_OK_IN(sup_ok),
    .LOW_POWER_OSC_CLOCK_IN(lpo_clk), .TCXO_PRESENT_IN(tcxo_pres), .CHIP_RESET_N_OUT(chip_rst_n),
    .POR_ACTIVE_OUT(por_act), .CLK_REQ_OUT(clk_req), .SLEEP_OUT(sleep), .STARTUP_DONE_OUT(done),
    .LPO_INTERNAL_SEL_OUT(lpo_int), .REF_CRYSTAL_SEL_OUT(xtal_sel));
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // bounded wait: 0 chip reset release, 1 clock request, 2 sleep end
  task automatic wait_for(input int sel, output int n);
    logic v;
    n = 0;
    do
    begin
      tick(1);
      n++;
      v = (sel == 0) ? chip_rst_n : (sel == 1) ? clk_req : !sleep;
    end while (v !== 1'b1 && n < 2000);
  endtask : wait_for
  task automatic restart(input logic hold, input logic lpo, input logic tcxo);
    rst_n = 1'b0;
    sup_on = 1'b0;
    hold_rst = hold;
    lpo_run = lpo;
    tcxo_fit = tcxo;
    tick(8);
    rst_n = 1'b1;
    tick(2);
    sup_on = 1'b1;
  endtask : restart
  task automatic after_release(input logic exp_int, input logic exp_xtal);
    int n;
    wait_for(1, n);
    check("clk_req delay", n, T_REQ + 1);
    check("still asleep", sleep, 1'b1);
    wait_for(2, n);
    check("sleep length", n, T_SLP - T_REQ);
    check("done", done, 1'b1);
    check("lpo internal", lpo_int, exp_int);
    check("crystal sel", xtal_sel, exp_xtal);
  endtask : after_release
  // ==========================================================
  // scenarios
  task automatic test_power_up;
    int n;
    restart(1'b0, 1'b1, 1'b1);
    check("reset state", {chip_rst_n, por_act, clk_req, sleep, done}, 5'h0A);
    wait_for(0, n);
    check("por length", (n >= T_POR + 1 && n <= T_POR + 6), 1'b1);
    check("por off", por_act, 1'b0);
    after_release(1'b0, 1'b0);
    $display("test power_up done");
  endtask : test_power_up
  task automatic test_pin_hold;
    int n;
    restart(1'b1, 1'b0, 1'b0);
    tick(T_POR + 20);
    check("held by pin", chip_rst_n, 1'b0);
    check("por over", por_act, 1'b0);
    hold_rst = 1'b0;
    wait_for(0, n);
    check("pin release", (n >= 2 && n <= 4), 1'b1);
    after_release(1'b1, 1'b1);
    $display("test pin_hold done");
  endtask : test_pin_hold
  task automatic test_reset_in_sleep;
    int n;
    restart(1'b0, 1'b1, 1'b0);
    wait_for(0, n);
    tick(20);
    check("req on", clk_req, 1'b1);
    hold_rst = 1'b1;
    tick(4);
    check("reset again", {chip_rst_n, clk_req, sleep, done}, 4'h2);
    hold_rst = 1'b0;
    wait_for(0, n);
    after_release(1'b0, 1'b1);
    $display("test reset_in_sleep done");
  endtask : test_reset_in_sleep
  task automatic test_supply_drop;
    int n;
    restart(1'b0, 1'b1, 1'b1);
    tick(20);
    sup_on = 1'b0;
    tick(4);
    check("por restarted", por_act, 1'b1);
    check("held by por", chip_rst_n, 1'b0);
    sup_on = 1'b1;
    wait_for(0, n);
    check("por full length", n, T_POR + 4);
    $display("test supply_drop done");
  endtask : test_supply_drop
  // ==========================================================
  // run control
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial
  begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    test_power_up();
    test_pin_hold();
    test_reset_in_sleep();
    test_supply_drop();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
